// *** write_line_loads.sv ***
// Write-line destination registers of the central processor datapath
`timescale 1ns/1ps

// Notes on behaviour
// - Terminal load copies all sixteen lines
// - Both-bank load splits lines over two selectors
// - Channel write goes to address bits 9..1
// - Erasable bank takes lines 11..9 only
// - Fixed bank takes lines 16, 14..11
// - Buffer load skipped at octal 20..23
// - Lower accumulator copies all sixteen lines
// - Overflow at 0025 bumps counter 0024
// - Overflow at 0026..0030 starts interrupt service
// - Return register copies all sixteen lines
// - Address register keeps lines 12..1 only
// - Addressed processor register takes sixteen lines
// - Sequence register takes lines 16, 14..10
// - Sequence extension bit copies long-opcode flag
// - Full adder load clears X, fills Y
// - Twelve-bit adder load fills Y low bits
// - Shifted adder load moves lines left one
// - Shifted load wraps sign unless inhibited, shift-incrementing, or pulse-filling with lower bit 15 set
// - Actions last 195 clocks (0.975 us at 5 ns), twelve per cycle
module write_line_loads import write_line_pkg::*; #(
	parameter int ACTION_CYCLES = ACTION_CYCLES_DEF,
	parameter int CHANNELS = CHANNEL_COUNT
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [WORD_W-1:0] write_lines,
	input wire logic load_terminal_pulse,
	input wire logic load_both_banks,
	input wire logic load_io_channel,
	input wire logic load_erasable_bank,
	input wire logic load_fixed_bank,
	input wire logic load_mem_buffer,
	input wire logic load_lower_acc,
	input wire logic overflow_count_check,
	input wire logic load_return_addr,
	input wire logic load_addr_pulse,
	input wire logic load_addressed_cpu_reg,
	input wire logic load_sequence_pulse,
	input wire logic load_adder_full,
	input wire logic load_adder_low_twelve,
	input wire logic load_adder_shifted,
	input wire logic long_opcode_flag,
	input wire logic shift_inc_seq,
	input wire logic pulse_fill_check,
	input wire logic carry_wrap_inhibit,
	input wire logic [CHAN_ADDR_W-1:0] chan_rd_addr,
	output logic [3:0] time_pulse,
	output logic action_last,
	output logic [WORD_W-1:0] terminal_reg,
	output logic [WORD_W-1:0] erasable_bank_sel,
	output logic [WORD_W-1:0] fixed_bank_sel,
	output logic [WORD_W-1:0] mem_buffer,
	output logic [WORD_W-1:0] lower_acc,
	output logic [WORD_W-1:0] return_addr,
	output logic [ADDR_W-1:0] addr_reg,
	output logic [SEQ_W-1:0] sequence_reg,
	output logic [WORD_W-1:0] adder_x,
	output logic [WORD_W-1:0] adder_y,
	output logic [WORD_W-1:0] chan_rd_data,
	output logic count_inc_req,
	output logic irq_service_instr
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ACTION_CYCLES < 2 || ACTION_CYCLES > (1 << TIMER_W)) begin : g_bad_action
		$error("action length out of timer range");
	end
	if (CHANNELS < 1 || CHANNELS > (1 << CHAN_ADDR_W)) begin : g_bad_chan
		$error("channel count out of range");
	end

	localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(ACTION_CYCLES - 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [TIMER_W-1:0] timer;
		logic [3:0] time_pulse;
		logic action_last;
		logic [WORD_W-1:0] terminal;
		logic [WORD_W-1:0] eb;
		logic [WORD_W-1:0] fb;
		logic [WORD_W-1:0] buffer;
		logic [WORD_W-1:0] lower;
		logic [WORD_W-1:0] ret;
		logic [ADDR_W-1:0] addr;
		logic [SEQ_W-1:0] seq;
		logic [WORD_W-1:0] x;
		logic [WORD_W-1:0] y;
		logic [CPU_FILE_DEPTH-1:0][WORD_W-1:0] cpu_file;
		logic [WORD_W-1:0] chan_rd;
	} core_state_type;

	core_state_type st_q;
	core_state_type st_d;

	// Channels are too many to reset; they live in a plain array
	logic [WORD_W-1:0] channel_mem [CHANNELS];
	logic chan_we;
	logic commit;
	logic edit_hit;
	logic cpu_sel_lower;
	logic cpu_sel_ret;
	logic cpu_sel_eb;
	logic cpu_sel_fb;
	logic cpu_sel_both;
	logic wrap_sign;

	ovf_watch_if ovw ();

	// Loads land on the last clock of an action, so the write lines
	// have settled from the read pulses of the same action
	assign commit = st_q.action_last;
	assign chan_we = commit && load_io_channel;
	assign edit_hit = (st_q.addr >= EDIT_ADDR_LO) && (st_q.addr <= EDIT_ADDR_HI);
	assign cpu_sel_lower = load_addressed_cpu_reg && (st_q.addr == CPU_LOWER_ACC_ADDR);
	assign cpu_sel_ret = load_addressed_cpu_reg && (st_q.addr == CPU_RETURN_ADDR);
	assign cpu_sel_eb = load_addressed_cpu_reg && (st_q.addr == CPU_EB_ADDR);
	assign cpu_sel_fb = load_addressed_cpu_reg && (st_q.addr == CPU_FB_ADDR);
	assign cpu_sel_both = load_addressed_cpu_reg && (st_q.addr == CPU_BOTH_BANK_ADDR);
	assign wrap_sign = !shift_inc_seq && !(st_q.lower[SIGN_BIT-1] && pulse_fill_check)
		&& !carry_wrap_inhibit;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		// Action timer and time pulse index
		if (st_q.timer == TIMER_LAST) begin
			st_d.timer = '0;
			st_d.time_pulse = (st_q.time_pulse == ACTIONS_PER_CYCLE) ? TIME_PULSE_FIRST
				: st_q.time_pulse + 4'h1;
		end else begin
			st_d.timer = st_q.timer + TIMER_W'(1);
		end
		st_d.action_last = (st_d.timer == TIMER_LAST);
		st_d.chan_rd = channel_mem[chan_rd_addr];

		if (commit) begin
			if (load_terminal_pulse) begin
				st_d.terminal = write_lines;
			end
			if (load_both_banks || cpu_sel_both) begin
				st_d.fb = '0;
				st_d.fb[FB_HI_BIT] = write_lines[SIGN_BIT];
				st_d.fb[FB_LO_TOP:FB_LO_BOT] = write_lines[FB_LO_TOP:FB_LO_BOT];
				st_d.eb = '0;
				st_d.eb[EB_TOP:EB_BOT] = write_lines[2:0];
			end
			if (load_erasable_bank || cpu_sel_eb) begin
				st_d.eb = '0;
				st_d.eb[EB_TOP:EB_BOT] = write_lines[EB_TOP:EB_BOT];
			end
			if (load_fixed_bank || cpu_sel_fb) begin
				st_d.fb = '0;
				st_d.fb[FB_HI_BIT] = write_lines[FB_HI_BIT];
				st_d.fb[FB_LO_TOP:FB_LO_BOT] = write_lines[FB_LO_TOP:FB_LO_BOT];
			end
			if (load_mem_buffer && !edit_hit) begin
				st_d.buffer = write_lines;
			end
			if (load_lower_acc || cpu_sel_lower) begin
				st_d.lower = write_lines;
			end
			if (load_return_addr || cpu_sel_ret) begin
				st_d.ret = write_lines;
			end
			if (load_addr_pulse) begin
				st_d.addr = write_lines[ADDR_W-1:0];
			end
			if (load_addressed_cpu_reg && st_q.addr < ADDR_W'(CPU_FILE_DEPTH)) begin
				st_d.cpu_file[st_q.addr[2:0]] = write_lines;
			end
			if (load_sequence_pulse) begin
				st_d.seq = '0;
				st_d.seq[SQ_SIGN_BIT] = write_lines[SIGN_BIT];
				st_d.seq[SQ_SIGN_BIT-1:0] = write_lines[SQ_LO_TOP:SQ_LO_BOT];
				st_d.seq[SQ_EXT_BIT] = long_opcode_flag;
			end
			// One adder load per action; the shifted form wins a clash
			if (load_adder_shifted) begin
				st_d.x = '0;
				st_d.y = {write_lines[SIGN_BIT], write_lines[SIGN_BIT-2:0], 1'b0};
				st_d.y[0] = wrap_sign && write_lines[SIGN_BIT];
			end else if (load_adder_low_twelve) begin
				st_d.x = '0;
				st_d.y = {4'h0, write_lines[ADDR_W-1:0]};
			end else if (load_adder_full) begin
				st_d.x = '0;
				st_d.y = write_lines;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
			st_q.time_pulse <= TIME_PULSE_FIRST;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (chan_we && int'(st_q.addr[CHAN_ADDR_W-1:0]) < CHANNELS) begin
			channel_mem[st_q.addr[CHAN_ADDR_W-1:0]] <= write_lines;
		end
	end

	// ----------------------------------------------------------------
	// Overflow watcher
	// ----------------------------------------------------------------
	assign ovw.check = commit && overflow_count_check;
	assign ovw.addr = st_q.addr;
	assign ovw.top_bits = write_lines[SIGN_BIT:OVF_BIT];

	ovf_watch u_ovf (
		.mclk(mclk),
		.rstn(rstn),
		.ov(ovw)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign time_pulse = st_q.time_pulse;
	assign action_last = st_q.action_last;
	assign terminal_reg = st_q.terminal;
	assign erasable_bank_sel = st_q.eb;
	assign fixed_bank_sel = st_q.fb;
	assign mem_buffer = st_q.buffer;
	assign lower_acc = st_q.lower;
	assign return_addr = st_q.ret;
	assign addr_reg = st_q.addr;
	assign sequence_reg = st_q.seq;
	assign adder_x = st_q.x;
	assign adder_y = st_q.y;
	assign chan_rd_data = st_q.chan_rd;
	assign count_inc_req = ovw.count_inc;
	assign irq_service_instr = ovw.irq_start;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_commit_terminal;
		action_last && load_terminal_pulse;
	endsequence

	sequence s_commit_shift;
		action_last && load_adder_shifted;
	endsequence

	AST_TERMINAL: assert property (s_commit_terminal |=> terminal_reg == $past(write_lines))
		else $error("terminal register load wrong");
	AST_BOTH_BANKS: assert property (action_last && load_both_banks && !load_erasable_bank
		&& !load_fixed_bank |=> erasable_bank_sel == {5'h00, $past(write_lines[2:0]), 8'h00}
		&& fixed_bank_sel[14] == 1'b0 && fixed_bank_sel[9:0] == 10'h000)
		else $error("both-bank load wrong");
	AST_EB: assert property (action_last && load_erasable_bank |=>
		erasable_bank_sel == ($past(write_lines) & 16'h0700))
		else $error("erasable bank load wrong");
	AST_FB: assert property (action_last && load_fixed_bank |=>
		fixed_bank_sel == ($past(write_lines) & 16'hBC00))
		else $error("fixed bank load wrong");
	AST_BUFFER_HOLD: assert property (action_last && load_mem_buffer && addr_reg >= 12'h010
		&& addr_reg <= 12'h013 |=> $stable(mem_buffer))
		else $error("buffer loaded at edit address");
	AST_LOWER: assert property (action_last && load_lower_acc |=> lower_acc == $past(write_lines))
		else $error("lower accumulator load wrong");
	AST_RETURN: assert property (action_last && load_return_addr |=> return_addr == $past(write_lines))
		else $error("return register load wrong");
	AST_ADDR: assert property (action_last && load_addr_pulse |=>
		addr_reg == $past(write_lines[11:0]))
		else $error("address register load wrong");
	AST_SEQ: assert property (action_last && load_sequence_pulse |=>
		sequence_reg[6] == $past(long_opcode_flag) && sequence_reg[5] == $past(write_lines[15]))
		else $error("sequence register load wrong");
	AST_ADDER_FULL: assert property (action_last && load_adder_full && !load_adder_shifted
		&& !load_adder_low_twelve |=> adder_x == 16'h0000 && adder_y == $past(write_lines))
		else $error("full adder load wrong");
	AST_ADDER_12: assert property (action_last && load_adder_low_twelve && !load_adder_shifted
		|=> adder_x == 16'h0000 && adder_y == {4'h0, $past(write_lines[11:0])})
		else $error("twelve-bit adder load wrong");
	AST_ADDER_SHIFT: assert property (s_commit_shift |=> adder_x == 16'h0000
		&& adder_y[15:1] == {$past(write_lines[15]), $past(write_lines[13:0])})
		else $error("shifted adder load wrong");
	AST_SHIFT_WRAP: assert property (s_commit_shift and carry_wrap_inhibit |=> adder_y[0] == 1'b0)
		else $error("sign wrapped while inhibited");
	AST_ACTION_LEN: assert property (action_last |=> !action_last [*2])
		else $error("action shorter than expected");
	AST_TIME_PULSE: assert property (action_last && time_pulse == 4'hC |=> time_pulse == 4'h1)
		else $error("time pulse did not wrap after twelve");

endmodule : write_line_loads

// *** write_line_pkg.sv ***
// Constants shared by the write-line destination logic
package write_line_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int ADDR_W = 12;
	localparam int CHAN_ADDR_W = 9;
	localparam int CHANNEL_COUNT = 512;
	localparam int SEQ_W = 7;
	localparam int TIMER_W = 8;
	localparam int CPU_FILE_DEPTH = 8;

	// ----------------------------------------------------------------
	// Action timing
	// ----------------------------------------------------------------
	localparam real ACTION_TIME_US = 0.977;
	localparam real CLK_PERIOD_NS = 5.0;
	// Longest time, so the count rounds down
	localparam int ACTION_CYCLES_DEF = int'($floor(ACTION_TIME_US * 1000.0 / CLK_PERIOD_NS));
	localparam logic [3:0] ACTIONS_PER_CYCLE = 4'hC;
	localparam logic [3:0] TIME_PULSE_FIRST = 4'h1;

	// ----------------------------------------------------------------
	// Bit fields (index 0 is write line 1)
	// ----------------------------------------------------------------
	localparam int SIGN_BIT = 15;
	localparam int OVF_BIT = 14;
	localparam int FB_HI_BIT = 15;
	localparam int FB_LO_TOP = 13;
	localparam int FB_LO_BOT = 10;
	localparam int EB_TOP = 10;
	localparam int EB_BOT = 8;
	localparam int SQ_LO_TOP = 13;
	localparam int SQ_LO_BOT = 9;
	localparam int SQ_EXT_BIT = 6;
	localparam int SQ_SIGN_BIT = 5;

	// ----------------------------------------------------------------
	// Special addresses (octal 20..23, 25, 26..30)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] EDIT_ADDR_LO = 12'h010;
	localparam logic [ADDR_W-1:0] EDIT_ADDR_HI = 12'h013;
	localparam logic [ADDR_W-1:0] OVF_COUNT_ADDR = 12'h015;
	localparam logic [ADDR_W-1:0] OVF_IRQ_ADDR_LO = 12'h016;
	localparam logic [ADDR_W-1:0] OVF_IRQ_ADDR_HI = 12'h018;

	// ----------------------------------------------------------------
	// Addressed processor registers
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CPU_LOWER_ACC_ADDR = 12'h001;
	localparam logic [ADDR_W-1:0] CPU_RETURN_ADDR = 12'h002;
	localparam logic [ADDR_W-1:0] CPU_EB_ADDR = 12'h003;
	localparam logic [ADDR_W-1:0] CPU_FB_ADDR = 12'h004;
	localparam logic [ADDR_W-1:0] CPU_BOTH_BANK_ADDR = 12'h006;

	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

endpackage : write_line_pkg

// *** ovf_watch_if.sv ***
// Interface between the load core and the overflow watcher
`timescale 1ns/1ps
interface ovf_watch_if;
	import write_line_pkg::*;
	logic check;
	logic [ADDR_W-1:0] addr;
	logic [1:0] top_bits;
	logic count_inc;
	logic irq_start;
	modport core (output check, output addr, output top_bits, input count_inc, input irq_start);
	modport watcher (input check, input addr, input top_bits, output count_inc, output irq_start);
endinterface : ovf_watch_if

// *** ovf_watch.sv ***
// Positive-overflow check that bumps a counter or starts interrupt service
`timescale 1ns/1ps
module ovf_watch import write_line_pkg::*; (
	input wire logic mclk,
	input wire logic rstn,
	ovf_watch_if.watcher ov
);

	typedef struct packed {
		logic count_inc;
		logic irq_start;
	} ovw_state_type;

	ovw_state_type s_q;
	ovw_state_type s_d;
	logic pos_ovf;

	assign pos_ovf = (ov.top_bits == 2'h1);

	always_comb begin
		s_d = '0;
		s_d.count_inc = ov.check && pos_ovf && (ov.addr == OVF_COUNT_ADDR);
		s_d.irq_start = ov.check && pos_ovf && (ov.addr >= OVF_IRQ_ADDR_LO)
			&& (ov.addr <= OVF_IRQ_ADDR_HI);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ov.count_inc = s_q.count_inc;
	assign ov.irq_start = s_q.irq_start;

	AST_OVF_COUNT: assert property (@(posedge mclk) disable iff (!rstn)
		ov.check && ov.top_bits == 2'h1 && ov.addr == OVF_COUNT_ADDR |=> ov.count_inc && !ov.irq_start)
		else $error("overflow counter not bumped");
	AST_OVF_IRQ: assert property (@(posedge mclk) disable iff (!rstn)
		ov.irq_start |-> $past(ov.check) && $past(ov.top_bits) == 2'h1
		&& $past(ov.addr) >= OVF_IRQ_ADDR_LO && $past(ov.addr) <= OVF_IRQ_ADDR_HI)
		else $error("interrupt service started without cause");

endmodule : ovf_watch

// *** pulse_seq_model.sv ***
// Behavioural control pulse sequencer that drives one action of pulses at a time
`timescale 1ns/1ps
module pulse_seq_model import write_line_pkg::*; (
	input wire logic mclk,
	input wire logic action_last,
	output logic [14:0] pulses,
	output logic [WORD_W-1:0] write_lines,
	output logic [3:0] quals
);
	initial begin
		pulses = 15'h0000;
		write_lines = 16'h0000;
		quals = 4'h0;
	end

	// ----------------------------------------------------------------
	// Action stepping
	// ----------------------------------------------------------------
	// Steps to just past the next commit edge and returns the cycles waited before that edge
	task automatic wait_commit(output int n);
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (action_last !== 1'b1 && n < 64);
		@(posedge mclk);
		#1;
	endtask : wait_commit

	// The whole pulse set is held from one action boundary to the next
	task automatic act(input logic [14:0] p, input logic [WORD_W-1:0] w, input logic [3:0] q);
		int n;
		wait_commit(n);
		pulses = p;
		write_lines = w;
		quals = q;
		wait_commit(n);
		pulses = 15'h0000;
		// A released bus must not keep showing the last word
		write_lines = ~w;
		quals = 4'h0;
	endtask : act
endmodule : pulse_seq_model

// *** write_line_loads_test.sv ***
// Self-checking testbench of the write-line destination registers
`timescale 1ns/1ps
module write_line_loads_test;
	import write_line_pkg::*;
	localparam int ACT_CYC = 4;
	localparam int P_BOTH = 1, P_CHAN = 2, P_EB = 3, P_FB = 4, P_BUF = 5, P_LACC = 6, P_OVF = 7;
	localparam int P_ADDR = 9, P_CPU = 10, P_SEQ = 11, P_Y12 = 13, P_YD = 14;
	logic mclk, rstn, action_last, count_inc_req, irq_service_instr;
	logic [14:0] pulses;
	logic [3:0] quals, time_pulse;
	logic [WORD_W-1:0] write_lines, terminal_reg, erasable_bank_sel, fixed_bank_sel, mem_buffer;
	logic [WORD_W-1:0] lower_acc, return_addr, adder_x, adder_y, chan_rd_data;
	logic [ADDR_W-1:0] addr_reg;
	logic [SEQ_W-1:0] sequence_reg;
	logic [CHAN_ADDR_W-1:0] chan_rd_addr;
	int miscompares = 0;
	int compares = 0;

	write_line_loads #(.ACTION_CYCLES(ACT_CYC)) write_line_loads_i (.mclk, .rstn, .write_lines,
		.load_terminal_pulse(pulses[0]), .load_both_banks(pulses[1]), .load_io_channel(pulses[2]),
		.load_erasable_bank(pulses[3]), .load_fixed_bank(pulses[4]), .load_mem_buffer(pulses[5]),
		.load_lower_acc(pulses[6]), .overflow_count_check(pulses[7]), .load_return_addr(pulses[8]),
		.load_addr_pulse(pulses[9]), .load_addressed_cpu_reg(pulses[10]), .load_sequence_pulse(pulses[11]),
		.load_adder_full(pulses[12]), .load_adder_low_twelve(pulses[13]), .load_adder_shifted(pulses[14]),
		.long_opcode_flag(quals[0]), .shift_inc_seq(quals[1]), .pulse_fill_check(quals[2]),
		.carry_wrap_inhibit(quals[3]), .chan_rd_addr, .time_pulse, .action_last, .terminal_reg,
		.erasable_bank_sel, .fixed_bank_sel, .mem_buffer, .lower_acc, .return_addr, .addr_reg, .sequence_reg,
		.adder_x, .adder_y, .chan_rd_data, .count_inc_req, .irq_service_instr);

	pulse_seq_model pulse_seq_model_i (.mclk, .action_last, .pulses, .write_lines, .quals);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic go(input int p, input logic [WORD_W-1:0] w, input logic [3:0] q);
		pulse_seq_model_i.act(15'h0001 << p, w, q);
	endtask : go

	task automatic final_report;
		if (miscompares == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	// Whole run needs a few hundred cycles; this leaves ample margin
	initial begin
		#50000;
		miscompares++;
		final_report();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		logic [ADDR_W-1:0] buf_addr [4] = '{12'h00F, 12'h010, 12'h013, 12'h014};
		logic [ADDR_W-1:0] ovf_addr [6] = '{12'h015, 12'h016, 12'h017, 12'h018, 12'h014, 12'h015};
		logic [WORD_W-1:0] ovf_word [6] = '{16'h4000, 16'h4000, 16'h4000, 16'h4000, 16'h4000, 16'hC000};
		logic [WORD_W-1:0] exp_buf;
		logic pos;
		logic [3:0] tp;
		int n;
		rstn = 1'b0;
		chan_rd_addr = 9'h000;
		repeat (2) @(posedge mclk);
		#1;
		check(time_pulse, 4'h1);
		check(terminal_reg, 16'h0000);
		rstn = 1'b1;
		// Sixteen-line destinations loaded together in one action
		pulse_seq_model_i.act(15'h1141, 16'hA5C3, 4'h0);
		check(terminal_reg, 16'hA5C3);
		check(lower_acc, 16'hA5C3);
		check(return_addr, 16'hA5C3);
		check(adder_y, 16'hA5C3);
		check(adder_x, 16'h0000);
		go(P_ADDR, 16'hF123, 4'h0);
		check(addr_reg, 12'h123);
		go(P_FB, 16'hFFFF, 4'h0);
		check(fixed_bank_sel, 16'hBC00);
		go(P_FB, 16'h43FF, 4'h0);
		check(fixed_bank_sel, 16'h0000);
		go(P_EB, 16'hFFFF, 4'h0);
		check(erasable_bank_sel, 16'h0700);
		go(P_EB, 16'hF8FF, 4'h0);
		check(erasable_bank_sel, 16'h0000);
		go(P_BOTH, 16'hBC07, 4'h0);
		check({fixed_bank_sel ^ 16'hBC00} | {erasable_bank_sel ^ 16'h0700}, 16'h0000);
		go(P_BOTH, 16'h43F8, 4'h0);
		check(fixed_bank_sel | erasable_bank_sel, 16'h0000);
		go(P_SEQ, 16'hFFFF, 4'h1);
		check(sequence_reg, 7'h7F);
		go(P_SEQ, 16'hC400, 4'h0);
		check(sequence_reg, 7'h22);
		go(P_Y12, 16'hFABC, 4'h0);
		check(adder_y, 16'h0ABC);
		check(adder_x, 16'h0000);
		// Lower accumulator bit 15 set so the pulse-fill case takes effect
		go(P_LACC, 16'h4000, 4'h0);
		check(lower_acc, 16'h4000);
		for (int i = 0; i < 4; i++) begin
			go(P_YD, 16'hC001, 4'h1 << i);
			check(adder_y, (i == 0) ? 16'h8003 : 16'h8002);
		end
		exp_buf = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			go(P_ADDR, {4'h0, buf_addr[i]}, 4'h0);
			go(P_BUF, {4'h9, buf_addr[i]}, 4'h0);
			exp_buf = (buf_addr[i] inside {[12'h010:12'h013]}) ? exp_buf : {4'h9, buf_addr[i]};
			check(mem_buffer, exp_buf);
		end
		for (int i = 0; i < 6; i++) begin
			go(P_ADDR, {4'h0, ovf_addr[i]}, 4'h0);
			go(P_OVF, ovf_word[i], 4'h0);
			pos = (ovf_word[i][15:14] == 2'b01);
			check(count_inc_req, pos && ovf_addr[i] == 12'h015);
			check(irq_service_instr, pos && ovf_addr[i] inside {[12'h016:12'h018]});
			@(posedge mclk);
			#1;
			check({count_inc_req, irq_service_instr}, 2'b00);
		end
		// Address bit 10 lies outside the channel field and must be ignored
		go(P_ADDR, 16'h0E05, 4'h0);
		go(P_CHAN, 16'h5AA5, 4'h0);
		go(P_ADDR, 16'h01FF, 4'h0);
		go(P_CHAN, 16'hC33C, 4'h0);
		chan_rd_addr = 9'h005;
		repeat (2) @(posedge mclk);
		#1;
		check(chan_rd_data, 16'h5AA5);
		chan_rd_addr = 9'h1FF;
		repeat (2) @(posedge mclk);
		#1;
		check(chan_rd_data, 16'hC33C);
		go(P_ADDR, 16'h0001, 4'h0);
		go(P_CPU, 16'h0F0F, 4'h0);
		check(lower_acc, 16'h0F0F);
		go(P_ADDR, 16'h0002, 4'h0);
		go(P_CPU, 16'hF0F0, 4'h0);
		check(return_addr, 16'hF0F0);
		for (int i = 0; i < 13; i++) begin
			tp = time_pulse;
			pulse_seq_model_i.wait_commit(n);
			check(n, ACT_CYC - 1);
			check(time_pulse, (tp == 4'hC) ? 4'h1 : tp + 4'h1);
		end
		final_report();
	end
endmodule : write_line_loads_test
